/* File: inc/irv_regs.svh */
// register offsets, field positions, reset values and vector addresses
`ifndef IRV_REGS_SVH
`define IRV_REGS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define IRV_OPTION_OFS 12'h0C8
`define IRV_STATUS_OFS 12'h0CC

// ----------------------------------------------------------------------
// interrupt_option_reg fields
// ----------------------------------------------------------------------
`define IRV_LVL_SEL_BIT 6
`define IRV_EDGE_POL_BIT 5
`define IRV_MASK_EN_BIT 4
`define IRV_OPTION_MASK 8'h70
`define IRV_OPTION_RST 8'h00

// ----------------------------------------------------------------------
// vector addresses in program space
// ----------------------------------------------------------------------
`define IRV_VEC_RESET 12'hFFE
`define IRV_VEC_NMI 12'hFFC
`define IRV_VEC_LINE1 12'hFF6
`define IRV_VEC_LINE2 12'hFF4
`define IRV_VEC_TIMER 12'hFF2
`define IRV_VEC_ADC 12'hFF0

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define IRV_RESP_OKAY 2'h0
`define IRV_RESP_SLVERR 2'h2

`endif

/* File: inc/irv_pkg.sv */
// types shared by the interrupt and reset vectoring block
`default_nettype none
package irv_pkg;
    typedef enum logic [3:0] {
        IRV_NORMAL = 4'h1,
        IRV_MASKED = 4'h2,
        IRV_NMI = 4'h4,
        IRV_NMI_NEST = 4'h8
    } irv_state_type;
endpackage
`default_nettype wire

/* File: rtl/irv_line_latch.sv */
// edge or level request detector for one external interrupt line
`default_nettype none
module irv_line_latch (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // line and mode
    input wire logic line,
    input wire logic level_mode,
    input wire logic rising,
    // service start
    input wire logic clear,
    // request
    output logic req
);
    logic prev_q;
    logic lat_q;
    logic edge_hit;

    assign edge_hit = rising ? (line & ~prev_q) : (~line & prev_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= line;
        end
    end

    // a second edge while latched is simply absorbed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lat_q <= 1'b0;
        end else if (level_mode) begin
            lat_q <= 1'b0;
        end else if (edge_hit) begin
            lat_q <= 1'b1;
        end else if (clear) begin
            lat_q <= 1'b0;
        end
    end

    // level mode stores nothing: the line is looked at when sampled
    assign req = level_mode ? ~line : lat_q;
endmodule
`default_nettype wire

/* File: rtl/irv_ctrl.sv */
// interrupt and reset vectoring controller with AXI4-Lite registers
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`include "irv_regs.svh"
`default_nettype none
module irv_ctrl #(
    parameter logic [3:0] STOP_WAKE_MASK = 4'h7
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write channels
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // request sources
    input wire logic nmi_pin_n,
    input wire logic line1,
    input wire logic line2,
    input wire logic timer_flag,
    input wire logic timer_ie,
    input wire logic adc_flag,
    input wire logic adc_ie,
    // core handshake
    input wire logic instr_done,
    input wire logic return_from_interrupt_instr,
    output logic vec_load,
    output logic [11:0] vec_addr,
    output logic stack_clear,
    output logic nmi_mode,
    output logic int_mode,
    // low-power wake
    output logic wake_wait,
    output logic wake_stop
);
    import irv_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    irv_state_type state_q;
    logic [7:0] option_q;
    logic boot_q;
    logic nmi_prev_q;
    logic nmi_lat_q;
    logic [3:0] req;
    logic line1_req;
    logic line2_req;
    logic global_mask_enable;
    logic line1_level_select;
    logic line2_edge_polarity;
    logic nmi_edge;
    logic take_nmi;
    logic take_mask;
    logic [3:0] grant;
    logic wr_go;
    logic wr_hit;
    logic rd_go;

    assign global_mask_enable = option_q[`IRV_MASK_EN_BIT];
    assign line1_level_select = option_q[`IRV_LVL_SEL_BIT];
    assign line2_edge_polarity = option_q[`IRV_EDGE_POL_BIT];

    // fixed order: lowest index wins
    function automatic logic [3:0] irv_first(input logic [3:0] r);
        logic [3:0] g;
        g = 4'h0;
        if (r[0]) begin
            g = 4'h1;
        end else if (r[1]) begin
            g = 4'h2;
        end else if (r[2]) begin
            g = 4'h4;
        end else if (r[3]) begin
            g = 4'h8;
        end
        return g;
    endfunction

    // ------------------------------------------------------------------
    // external line detectors
    // ------------------------------------------------------------------
    irv_line_latch u_line1 (
        .clk(clk),
        .rst(rst),
        .line(line1),
        .level_mode(line1_level_select),
        .rising(1'b0),
        .clear(take_mask && grant[0]),
        .req(line1_req)
    );

    irv_line_latch u_line2 (
        .clk(clk),
        .rst(rst),
        .line(line2),
        .level_mode(1'b0),
        .rising(line2_edge_polarity),
        .clear(take_mask && grant[1]),
        .req(line2_req)
    );

    // ------------------------------------------------------------------
    // request collection
    // ------------------------------------------------------------------
    // shared events arrive already ORed; flags stay with their owners
    assign req[0] = line1_req;
    assign req[1] = line2_req;
    assign req[2] = timer_flag & timer_ie;
    assign req[3] = adc_flag & adc_ie;

    assign nmi_edge = nmi_prev_q & ~nmi_pin_n;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_prev_q <= 1'b1;
        end else begin
            nmi_prev_q <= nmi_pin_n;
        end
    end

    // a new edge in the entry cycle must survive the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_lat_q <= 1'b0;
        end else if (nmi_edge) begin
            nmi_lat_q <= 1'b1;
        end else if (take_nmi) begin
            nmi_lat_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // acceptance
    // ------------------------------------------------------------------
    assign take_nmi = instr_done && !boot_q && nmi_lat_q &&
        (state_q == IRV_NORMAL || state_q == IRV_MASKED);
    assign take_mask = instr_done && !boot_q && !take_nmi &&
        state_q == IRV_NORMAL && global_mask_enable && (|req);
    // grant only matters while take_mask is high
    assign grant = irv_first(req);

    // reset always lands in non-maskable mode, dropping any routine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= IRV_NMI;
        end else if (take_nmi) begin
            state_q <= (state_q == IRV_MASKED) ? IRV_NMI_NEST : IRV_NMI;
        end else if (take_mask) begin
            state_q <= IRV_MASKED;
        end else if (return_from_interrupt_instr && !boot_q) begin
            unique case (state_q)
                IRV_NMI_NEST: state_q <= IRV_MASKED;
                IRV_NMI: state_q <= IRV_NORMAL;
                IRV_MASKED: state_q <= IRV_NORMAL;
                IRV_NORMAL: state_q <= IRV_NORMAL;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // vector output
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vec_load <= 1'b0;
            vec_addr <= `IRV_VEC_RESET;
            stack_clear <= 1'b0;
        end else begin
            vec_load <= boot_q || take_nmi || take_mask;
            stack_clear <= boot_q;
            if (boot_q) begin
                vec_addr <= `IRV_VEC_RESET;
            end else if (take_nmi) begin
                vec_addr <= `IRV_VEC_NMI;
            end else if (take_mask) begin
                unique case (1'b1)
                    grant[0]: vec_addr <= `IRV_VEC_LINE1;
                    grant[1]: vec_addr <= `IRV_VEC_LINE2;
                    grant[2]: vec_addr <= `IRV_VEC_TIMER;
                    grant[3]: vec_addr <= `IRV_VEC_ADC;
                endcase
            end
        end
    end

    assign nmi_mode = (state_q == IRV_NMI) || (state_q == IRV_NMI_NEST);
    assign int_mode = (state_q == IRV_MASKED);

    // with the enable clear even the non-maskable input cannot wake
    assign wake_wait = global_mask_enable && (nmi_lat_q || (|req));
    assign wake_stop = global_mask_enable &&
        (nmi_lat_q || (|(req & STOP_WAKE_MASK)));

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    // both halves of a write are taken together, one write in flight
    assign awready = awvalid && wvalid && !bvalid;
    assign wready = awready;
    assign wr_go = awready;
    // exact match: an unaligned address falls through to an error
    assign wr_hit = awaddr == `IRV_OPTION_OFS;
    assign arready = !rvalid;
    assign rd_go = arvalid && arready;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            option_q <= `IRV_OPTION_RST;
        end else if (wr_go && wr_hit && wstrb[0]) begin
            option_q <= wdata[7:0] & `IRV_OPTION_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp <= `IRV_RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= (wr_hit || awaddr == `IRV_STATUS_OFS) ?
                `IRV_RESP_OKAY : `IRV_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // option register is write-only and reads as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `IRV_RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata <= 32'h0;
            rresp <= `IRV_RESP_OKAY;
            if (araddr == `IRV_STATUS_OFS) begin
                rdata <= {20'h0, state_q, req, 3'h0, nmi_lat_q};
            end else if (araddr != `IRV_OPTION_OFS) begin
                rresp <= `IRV_RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // core link
    nmi_entry_a: assert property (
        take_nmi |=> vec_load && vec_addr == `IRV_VEC_NMI && nmi_mode)
        else $error("nmi entry did not load its vector");
    nmi_nonest_a: assert property (
        nmi_mode && !boot_q |=> !vec_load)
        else $error("nmi preempted another nmi");
    enable_gate_a: assert property (
        !global_mask_enable && !boot_q |=>
            !vec_load || vec_addr == `IRV_VEC_NMI)
        else $error("maskable taken while masked");
    prio_line1_a: assert property (
        take_mask && req[0] |=> vec_addr == `IRV_VEC_LINE1 && int_mode)
        else $error("vector 1 not served first");
    prio_adc_a: assert property (
        take_mask && req == 4'h8 |=> vec_addr == `IRV_VEC_ADC)
        else $error("vector 4 wrong address");
    boot_vec_a: assert property (
        $fell(boot_q) |-> vec_load && stack_clear &&
            vec_addr == `IRV_VEC_RESET && nmi_mode)
        else $error("reset vector not issued");
    wake_wait_a: assert property (
        global_mask_enable && (|req) |-> wake_wait)
        else $error("request did not wake from wait");
    stop_adc_a: assert property (
        req == 4'h8 && !nmi_lat_q |-> !wake_stop)
        else $error("converter woke from stop");
    nmi_latch_a: assert property (
        nmi_edge && !take_nmi |=> nmi_lat_q)
        else $error("nmi edge lost");
    // register bus and wake outputs
    wr_resp_a: assert property (
        wr_go |=> $rose(bvalid))
        else $error("write not answered");
    rd_resp_a: assert property (
        rd_go |=> $rose(rvalid))
        else $error("read not answered");
    line_stop_a: assert property (
        global_mask_enable && (req[0] || req[1]) |-> wake_stop)
        else $error("port line did not wake from stop");
    nmi_wake_a: assert property (
        global_mask_enable && nmi_lat_q |-> wake_wait && wake_stop)
        else $error("nmi did not wake the core");
endmodule
`default_nettype wire

/* File: verification/irv_core_model.sv */
// core-side model: instruction completion, return pulses and stack depth
`default_nettype none
module irv_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // commands from the bench
    input wire logic step,
    input wire logic ret,
    // design handshake
    input wire logic vec_load,
    input wire logic stack_clear,
    output logic instr_done,
    output logic return_from_interrupt_instr,
    // stack level for the bench
    output logic [2:0] stack_depth
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] depth_q;
    // --------------------
    // core pulses
    // --------------------
    assign instr_done = step;
    assign stack_depth = depth_q;
    // software ends every routine, init included, with a return
    assign return_from_interrupt_instr = ret;
    // six-level stack: stays at its deepest level when overrun
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            depth_q <= 3'h0;
        end else if (stack_clear) begin
            depth_q <= 3'h0;
        end else if (vec_load && depth_q != 3'h6) begin
            depth_q <= depth_q + 3'h1;
        end else if (ret && depth_q != 3'h0) begin
            depth_q <= depth_q - 3'h1;
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the interrupt and reset vectoring controller
`include "irv_regs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, nmi_pin_n, line1, line2;
    logic timer_flag, timer_ie, adc_flag, adc_ie, instr_done, step, ret;
    logic return_from_interrupt_instr, vec_load, stack_clear;
    logic nmi_mode, int_mode, wake_wait, wake_stop;
    logic [11:0] awaddr, araddr, vec_addr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [2:0] stack_depth;
    int mismatches = 0;
    int n_checks = 0;
    irv_ctrl irv_ctrl_i (.clk, .rst, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .nmi_pin_n,
        .line1, .line2, .timer_flag, .timer_ie, .adc_flag, .adc_ie,
        .instr_done, .return_from_interrupt_instr, .vec_load, .vec_addr,
        .stack_clear, .nmi_mode, .int_mode, .wake_wait, .wake_stop);
    irv_core_model irv_core_model_i (.clk, .rst, .step, .ret, .vec_load,
        .stack_clear, .instr_done, .return_from_interrupt_instr,
        .stack_depth);
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // --------------------
    // bus and check tasks
    // --------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do @(posedge clk); while (!awready);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask
    task automatic opt(input logic [2:0] f);
        logic [1:0] r;
        wr(`IRV_OPTION_OFS, {25'h0, f, 4'h0}, r);
        chk("option bresp", r, `IRV_RESP_OKAY);
    endtask
    task automatic st(input logic [11:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(`IRV_STATUS_OFS, d, r);
        chk("status", d[11:0], e);
    endtask
    // zero means no vector load may follow this instruction end
    task automatic take(input logic [11:0] e);
        @(posedge clk);
        step <= 1'h1;
        @(posedge clk);
        step <= 1'h0;
        #1;
        chk("vec_load", vec_load, e != 12'h000);
        if (e != 12'h000) chk("vec_addr", vec_addr, e);
    endtask
    task automatic rti();
        @(posedge clk);
        ret <= 1'h1;
        @(posedge clk);
        ret <= 1'h0;
        #1;
    endtask
    // edge detectors latch the request on the first clock edge after the pins move
    task automatic pins(input logic n, l1, l2);
        @(posedge clk);
        nmi_pin_n <= n;
        line1 <= l1;
        line2 <= l2;
        cyc(2);
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'h1;
        cyc(4);
        #1;
        chk("nmi_mode in reset", nmi_mode, 1'h1);
        chk("vec_load in reset", vec_load, 1'h0);
        @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
        chk("reset load", vec_load, 1'h1);
        chk("stack_clear", stack_clear, 1'h1);
        chk("reset vector", vec_addr, `IRV_VEC_RESET);
    endtask
    // --------------------
    // scenarios
    // --------------------
    task automatic t_boot();
        opt(3'h1);
        pins(1'h1, 1'h0, 1'h1);
        pins(1'h1, 1'h1, 1'h1);
        take(12'h000);
        rti();
        chk("nmi_mode", nmi_mode, 1'h0);
        take(`IRV_VEC_LINE1);
        chk("int_mode", int_mode, 1'h1);
        rti();
        $display("t_boot done");
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd(`IRV_OPTION_OFS, d, r);
        chk("option read", d, 32'h0);
        chk("option rresp", r, `IRV_RESP_OKAY);
        wr(12'h100, 32'hFFFF_FFFF, r);
        chk("unmapped write", r, `IRV_RESP_SLVERR);
        rd(12'h100, d, r);
        chk("unmapped read", r, `IRV_RESP_SLVERR);
        wr(`IRV_STATUS_OFS, 32'h0000_0FFF, r);
        chk("status write", r, `IRV_RESP_OKAY);
        st(12'h100);
        $display("t_regs done");
    endtask
    task automatic t_enable();
        opt(3'h0);
        pins(1'h1, 1'h0, 1'h1);
        pins(1'h1, 1'h1, 1'h1);
        take(12'h000);
        st(12'h110);
        opt(3'h1);
        take(`IRV_VEC_LINE1);
        st(12'h200);
        rti();
        $display("t_enable done");
    endtask
    task automatic t_prio();
        logic [11:0] v [4] = '{`IRV_VEC_LINE1, `IRV_VEC_LINE2,
            `IRV_VEC_TIMER, `IRV_VEC_ADC};
        pins(1'h1, 1'h0, 1'h0);
        pins(1'h1, 1'h1, 1'h1);
        timer_flag <= 1'h1;
        timer_ie <= 1'h1;
        adc_flag <= 1'h1;
        adc_ie <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            take(v[i]);
            take(12'h000);
            @(posedge clk);
            // software clears the flag of the source it served
            if (i == 2) timer_flag <= 1'h0;
            if (i == 3) adc_flag <= 1'h0;
            rti();
        end
        @(posedge clk);
        adc_flag <= 1'h1;
        adc_ie <= 1'h0;
        take(12'h000);
        opt(3'h0);
        timer_flag <= 1'h1;
        take(12'h000);
        @(posedge clk);
        timer_flag <= 1'h0;
        adc_flag <= 1'h0;
        $display("t_prio done");
    endtask
    task automatic t_nmi();
        pins(1'h0, 1'h1, 1'h1);
        pins(1'h1, 1'h1, 1'h1);
        take(`IRV_VEC_NMI);
        rti();
        opt(3'h1);
        pins(1'h1, 1'h0, 1'h1);
        pins(1'h1, 1'h1, 1'h1);
        take(`IRV_VEC_LINE1);
        pins(1'h0, 1'h1, 1'h1);
        pins(1'h1, 1'h1, 1'h1);
        take(`IRV_VEC_NMI);
        st(12'h800);
        pins(1'h0, 1'h1, 1'h1);
        pins(1'h1, 1'h1, 1'h1);
        take(12'h000);
        rti();
        chk("back to maskable", {nmi_mode, int_mode}, 2'h1);
        chk("stack depth", stack_depth, 3'h1);
        take(`IRV_VEC_NMI);
        rti();
        rti();
        chk("normal", {nmi_mode, int_mode}, 2'h0);
        $display("t_nmi done");
    endtask
    task automatic t_edge();
        opt(3'h7);
        pins(1'h1, 1'h0, 1'h1);
        take(`IRV_VEC_LINE1);
        rti();
        pins(1'h1, 1'h1, 1'h1);
        take(12'h000);
        pins(1'h1, 1'h1, 1'h0);
        take(12'h000);
        pins(1'h1, 1'h1, 1'h1);
        take(`IRV_VEC_LINE2);
        rti();
        for (int i = 0; i < 2; i++) begin
            pins(1'h1, 1'h1, 1'h0);
            pins(1'h1, 1'h1, 1'h1);
        end
        take(`IRV_VEC_LINE2);
        rti();
        take(12'h000);
        $display("t_edge done");
    endtask
    task automatic t_wake();
        opt(3'h1);
        #1;
        chk("wake_wait idle", wake_wait, 1'h0);
        @(posedge clk);
        adc_flag <= 1'h1;
        adc_ie <= 1'h1;
        cyc(2);
        #1;
        chk("wake_wait", wake_wait, 1'h1);
        chk("wake_stop adc", wake_stop, 1'h0);
        @(posedge clk);
        timer_flag <= 1'h1;
        timer_ie <= 1'h1;
        adc_flag <= 1'h0;
        cyc(2);
        #1;
        chk("wake_stop timer", wake_stop, 1'h1);
        @(posedge clk);
        timer_flag <= 1'h0;
        $display("t_wake done");
    endtask
    task automatic t_abort();
        pins(1'h0, 1'h1, 1'h1);
        pins(1'h1, 1'h1, 1'h1);
        take(`IRV_VEC_NMI);
        do_reset();
        chk("int_mode", int_mode, 1'h0);
        st(12'h400);
        rti();
        chk("nmi_mode", nmi_mode, 1'h0);
        $display("t_abort done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        cyc(5000);
        mismatches++;
        summarize();
    end
    initial begin
        rst = 1'h1;
        {awaddr, araddr, wdata} = 56'h0;
        {awvalid, wvalid, bready, arvalid, rready, step, ret} = 7'h0;
        {timer_flag, timer_ie, adc_flag, adc_ie} = 4'h0;
        {nmi_pin_n, line1, line2} = 3'h7;
        wstrb = 4'hF;
        do_reset();
        t_boot();
        t_regs();
        t_enable();
        t_prio();
        t_nmi();
        t_edge();
        t_wake();
        t_abort();
        summarize();
    end
endmodule
`default_nettype wire
